//--- logic/ddr_cmd_if.sv
// Command link between the memory controller end and the memory device end.
`timescale 1ns/1ps
interface ddr_cmd_if;
  import dll_switch_pkg::*;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic              odt;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
  modport dram (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface

//--- logic/dll_mode_switch_sequencer.sv
// Controller end: drives the DLL on/off switch through self refresh.
`timescale 1ns/1ps
module dll_mode_switch_sequencer
  import dll_switch_pkg::*;
#(
  parameter int unsigned MOD_P    = MOD_CYC,
  parameter int unsigned MRD_P    = MRD_CYC,
  parameter int unsigned CKSRE_P  = CKSRE_CYC,
  parameter int unsigned CKSRX_P  = CKSRX_CYC,
  parameter int unsigned XS_P     = XS_CYC,
  parameter int unsigned DLLK_P   = DLLK_CYC,
  parameter int unsigned ZQOPER_P = ZQOPER_CYC
)(
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic             to_dll_off_i,
  input  wire logic             zq_long_i,
  input  wire logic [LAT_W-1:0] cl_code_i,
  input  wire logic [LAT_W-1:0] cwl_code_i,
  input  wire logic             odt_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic                  freq_change_o,
  ddr_cmd_if.ctrl               link
);

  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_MR1   = 11'h002,
    S_SRE   = 11'h004,
    S_FREQ  = 11'h008,
    S_SRX   = 11'h010,
    S_MR1ON = 11'h020,
    S_MR0   = 11'h040,
    S_MR2   = 11'h080,
    S_ZQ    = 11'h100,
    S_FIN   = 11'h200,
    S_DONE  = 11'h400
  } state_t;

  state_t              state_q, state_d;
  logic [CNT_W-1:0]    cnt_q, cnt_d;
  logic [CNT_W-1:0]    lock_q, lock_d;
  logic                off_q, off_d;
  logic                zq_q, zq_d;
  logic [LAT_W-1:0]    cl_q, cl_d;
  logic [LAT_W-1:0]    cwl_q, cwl_d;
  logic                first_q, first_d;
  logic                cke_q, cke_d;
  logic [3:0]          cmd_q, cmd_d;
  logic [BA_W-1:0]     ba_q, ba_d;
  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic                odt_q, odt_d;
  logic                busy_q, busy_d;
  logic                done_q, done_d;
  logic                freq_q, freq_d;

  // Wait length that follows the command issued on entry to each state.
  function automatic logic [CNT_W-1:0] wait_of(input state_t s);
    logic [CNT_W-1:0] w;
    w = CNT_W'(1);
    case (s)
      S_MR1:   w = CNT_W'(MOD_P);                   // [RQ3]
      S_SRE:   w = CNT_W'(CKSRE_P);                 // [RQ3] [RQ9]
      S_FREQ:  w = CNT_W'(CKSRX_P);                 // [RQ4]
      S_SRX:   w = CNT_W'(XS_P);                    // [RQ7] [RQ12]
      S_MR1ON: w = CNT_W'(MRD_P);                   // [RQ13]
      S_MR0:   w = CNT_W'(MRD_P);                   // [RQ14] [RQ17]
      S_MR2:   w = CNT_W'(MOD_P);                   // [RQ8] [RQ14]
      S_ZQ:    w = CNT_W'(ZQOPER_P);                // [RQ16]
      default: w = CNT_W'(1);
    endcase
    return w;
  endfunction

  // Sequence state, wait counters and the registered command bus.
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    lock_d  = (lock_q != '0) ? lock_q - CNT_W'(1) : lock_q; // [RQ17]
    off_d   = off_q;
    zq_d    = zq_q;
    cl_d    = cl_q;
    cwl_d   = cwl_q;
    first_d = 1'b0;
    cke_d   = cke_q;
    cmd_d   = CMD_NOP;                              // [RQ21]
    ba_d    = '0;
    addr_d  = '0;
    odt_d   = 1'b0;                                 // [RQ6] [RQ11]
    busy_d  = busy_q;
    done_d  = 1'b0;
    freq_d  = 1'b0;
    if (first_q)
    begin
      cnt_d = wait_of(state_q) - CNT_W'(1);
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - CNT_W'(1);
    end
    case (state_q)
      S_IDLE:
      begin
        odt_d = odt_i;
        cke_d = 1'b1;
        if (start_i)
        begin
          // Caller starts only from idle with banks precharged.
          off_d   = to_dll_off_i;                   // [RQ2] [RQ9]
          zq_d    = zq_long_i;
          cl_d    = to_dll_off_i ? CL6_CODE : cl_code_i;
          cwl_d   = to_dll_off_i ? CWL6_CODE : cwl_code_i;
          busy_d  = 1'b1;
          odt_d   = 1'b0;                           // [RQ2] [RQ9]
          first_d = 1'b1;
          state_d = to_dll_off_i ? S_MR1 : S_SRE;
          if (to_dll_off_i)
          begin
            cmd_d  = CMD_MRS;
            ba_d   = BA_MR1;
            addr_d = ADDR_W'(1) << MR1_DLL_OFF_BIT;  // [RQ1]
          end
          else
          begin
            cmd_d = CMD_REF;
            cke_d = 1'b0;
          end
        end
      end
      S_MR1:
      begin
        if (!first_q && cnt_q == '0)
        begin
          cmd_d   = CMD_REF;                        // [RQ3]
          cke_d   = 1'b0;
          first_d = 1'b1;
          state_d = S_SRE;
        end
      end
      S_SRE:
      begin
        if (!first_q && cnt_q == '0)
        begin
          freq_d  = 1'b1;
          first_d = 1'b1;
          state_d = S_FREQ;
        end
      end
      S_FREQ:
      begin
        freq_d = 1'b1;
        if (!first_q && cnt_q == '0)
        begin
          freq_d  = 1'b0;
          cke_d   = 1'b1;                           // [RQ5] [RQ10]
          first_d = 1'b1;
          state_d = S_SRX;
        end
      end
      S_SRX:
      begin
        if (!first_q && cnt_q == '0)
        begin
          cmd_d   = CMD_MRS;
          first_d = 1'b1;
          if (off_q)
          begin
            ba_d    = BA_MR0;                       // [RQ7]
            addr_d  = ADDR_W'(cl_q) << MR0_CL_LSB;
            state_d = S_MR0;
          end
          else
          begin
            ba_d    = BA_MR1;                       // [RQ12]
            state_d = S_MR1ON;
          end
        end
      end
      S_MR1ON:
      begin
        if (!first_q && cnt_q == '0)
        begin
          cmd_d   = CMD_MRS;
          ba_d    = BA_MR0;
          addr_d  = (ADDR_W'(cl_q) << MR0_CL_LSB)
                  | (ADDR_W'(1) << MR0_DLL_RST_BIT); // [RQ13]
          lock_d  = CNT_W'(DLLK_P);                 // [RQ10] [RQ15]
          first_d = 1'b1;
          state_d = S_MR0;
        end
      end
      S_MR0:
      begin
        if (!first_q && cnt_q == '0)
        begin
          cmd_d   = CMD_MRS;                        // [RQ14]
          ba_d    = BA_MR2;
          addr_d  = ADDR_W'(cwl_q) << MR2_CWL_LSB;
          first_d = 1'b1;
          state_d = S_MR2;
        end
      end
      S_MR2:
      begin
        if (!first_q && cnt_q == '0)
        begin
          first_d = 1'b1;
          state_d = S_FIN;
          if (zq_q)
          begin
            cmd_d   = CMD_ZQ;                       // [RQ7] [RQ14]
            addr_d  = ADDR_W'(1) << ZQ_LONG_BIT;
            state_d = S_ZQ;
          end
        end
      end
      S_ZQ:
      begin
        if (!first_q && cnt_q == '0)
        begin
          first_d = 1'b1;
          state_d = S_FIN;
        end
      end
      S_FIN:
      begin
        // Hold ODT low and CKE high until the DLL has relocked.
        if (!first_q && cnt_q == '0 && lock_q == '0) // [RQ15]
        begin
          done_d  = 1'b1;
          busy_d  = 1'b0;
          state_d = S_DONE;
        end
      end
      S_DONE:
      begin
        odt_d   = odt_i;
        state_d = S_IDLE;
      end
      default:
      begin
        state_d = S_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  // Register stage; every link and user output comes from here.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
      lock_q  <= '0;
      off_q   <= 1'b0;
      zq_q    <= 1'b0;
      cl_q    <= '0;
      cwl_q   <= '0;
      first_q <= 1'b0;
      cke_q   <= 1'b0;
      cmd_q   <= CMD_NOP;
      ba_q    <= '0;
      addr_q  <= '0;
      odt_q   <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      freq_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      lock_q  <= lock_d;
      off_q   <= off_d;
      zq_q    <= zq_d;
      cl_q    <= cl_d;
      cwl_q   <= cwl_d;
      first_q <= first_d;
      cke_q   <= cke_d;
      cmd_q   <= cmd_d;
      ba_q    <= ba_d;
      addr_q  <= addr_d;
      odt_q   <= odt_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      freq_q  <= freq_d;
    end
  end

  // Drive the link from the registered command.
  assign link.cke   = cke_q;
  assign link.cs_n  = cmd_q[3];
  assign link.ras_n = cmd_q[2];
  assign link.cas_n = cmd_q[1];
  assign link.we_n  = cmd_q[0];
  assign link.ba    = ba_q;
  assign link.addr  = addr_q;
  assign link.odt   = odt_q;
  assign busy_o        = busy_q;
  assign done_o        = done_q;
  assign freq_change_o = freq_q;

endmodule // dll_mode_switch_sequencer

//--- logic/dll_switch_pkg.sv
// Shared constants for the DLL on/off switching sequencer and its memory-side end.
// Notes on behaviour
// [RQ1] Mode register one bit 0 set disables DLL.
// [RQ2] Controller starts idle, precharged, termination off.
// [RQ3] Wait update delay, self refresh, clock hold.
// [RQ4] Stable new clock before self refresh exit.
// [RQ5] DLL-off: CKE high until update delays elapse.
// [RQ6] DLL-off: ODT low until update delays elapse.
// [RQ7] DLL-off: exit delay, then rewrite mode registers.
// [RQ8] After last write, update delay, then ready.
// [RQ9] DLL-on: idle, termination off, clock hold.
// [RQ10] DLL-on: CKE high until lock time elapses.
// [RQ11] DLL-on: ODT low until lock time elapses.
// [RQ12] DLL-on: exit delay, then clear bit 0.
// [RQ13] Spacing, then zero-register bit 8 resets DLL.
// [RQ14] Spacing after reset, then rewrite other registers.
// [RQ15] No locked-DLL command before lock time.
// [RQ16] Long calibration adds its own wait.
// [RQ17] Cycle delays count real clock edges.
// [RQ18] Nanosecond delays round up to cycles.
// [RQ19] Deselect cycles issue no new command.
// [RQ20] DLL off forces latencies of six.
// [RQ21] Waits carry only no-operation cycles.
package dll_switch_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned CNT_W           = 10;
  // Delays given in nanoseconds, converted by rounding up.
  localparam int unsigned CKSRE_NS        = 10;
  localparam int unsigned CKSRX_NS        = 10;
  localparam int unsigned XS_NS           = 120;
  localparam int unsigned MOD_NS          = 15;
  localparam int unsigned CKSRE_CYC = (CKSRE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // [RQ18]
  localparam int unsigned CKSRX_CYC = (CKSRX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // [RQ18]
  localparam int unsigned XS_CYC    = (XS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;    // [RQ18]
  localparam int unsigned MOD_NS_CYC = (MOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Delays given in clock cycles.
  localparam int unsigned MOD_MIN_CYC     = 12;
  localparam int unsigned MOD_CYC   = (MOD_MIN_CYC > MOD_NS_CYC) ? MOD_MIN_CYC : MOD_NS_CYC;
  localparam int unsigned MRD_CYC         = 4;
  localparam int unsigned DLLK_CYC        = 512;
  localparam int unsigned ZQOPER_CYC      = 256;
  // Link widths and mode register fields.
  localparam int unsigned BA_W            = 3;
  localparam int unsigned ADDR_W          = 14;
  localparam logic [2:0]  BA_MR0          = 3'h0;
  localparam logic [2:0]  BA_MR1          = 3'h1;
  localparam logic [2:0]  BA_MR2          = 3'h2;
  localparam int unsigned MR1_DLL_OFF_BIT = 0;
  localparam int unsigned MR0_DLL_RST_BIT = 8;
  localparam int unsigned MR0_CL_LSB      = 4;
  localparam int unsigned MR2_CWL_LSB     = 3;
  localparam int unsigned LAT_W           = 3;
  localparam int unsigned ZQ_LONG_BIT     = 10;
  localparam logic [3:0]  CL_BASE         = 4'h4;
  localparam logic [3:0]  CWL_BASE        = 4'h5;
  localparam logic [3:0]  DLL_OFF_LAT     = 4'h6;
  localparam logic [2:0]  CL6_CODE        = 3'h2;
  localparam logic [2:0]  CWL6_CODE       = 3'h1;
  // Command encodings on cs_n, ras_n, cas_n, we_n.
  localparam logic [3:0]  CMD_NOP         = 4'h7;
  localparam logic [3:0]  CMD_MRS         = 4'h0;
  localparam logic [3:0]  CMD_REF         = 4'h1;
  localparam logic [3:0]  CMD_ZQ          = 4'h6;
endpackage

//--- logic/dram_dll_mode_end.sv
// Memory end: obeys DLL disable and reset writes and tracks update and lock delays.
`timescale 1ns/1ps
module dram_dll_mode_end
  import dll_switch_pkg::*;
#(
  parameter int unsigned MOD_P  = MOD_CYC,
  parameter int unsigned DLLK_P = DLLK_CYC
)(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  ddr_cmd_if.dram                link,
  output logic                   dll_off_o,
  output logic                   dll_locked_o,
  output logic                   self_refresh_o,
  output logic                   cmd_ready_o,
  output logic [3:0]             read_latency_o,
  output logic [3:0]             write_latency_o
);

  logic             cke_prev_q;
  logic             dll_off_q, dll_off_d;
  logic             sr_q, sr_d;
  logic [CNT_W-1:0] mod_q, mod_d;
  logic [CNT_W-1:0] lock_q, lock_d;
  logic [LAT_W-1:0] cl_q, cl_d;
  logic [LAT_W-1:0] cwl_q, cwl_d;
  logic [3:0]       rl_q, rl_d;
  logic [3:0]       wl_q, wl_d;
  logic             locked_q, locked_d;
  logic             ready_q, ready_d;
  logic [3:0]       cmd;
  logic             sel;

  assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  // A deselected or powered-down cycle carries no new command.
  assign sel = !link.cs_n && link.cke && cke_prev_q && !sr_q;  // [RQ19]

  // Mode register decode, self refresh tracking and delay counters.
  always_comb
  begin
    dll_off_d = dll_off_q;
    sr_d      = sr_q;
    cl_d      = cl_q;
    cwl_d     = cwl_q;
    mod_d     = (mod_q != '0) ? mod_q - CNT_W'(1) : mod_q;    // [RQ17]
    lock_d    = (lock_q != '0) ? lock_q - CNT_W'(1) : lock_q;
    if (cke_prev_q && !link.cke && !link.cs_n && cmd == CMD_REF)
    begin
      sr_d = 1'b1;
    end
    else if (sr_q && link.cke)
    begin
      sr_d = 1'b0;
    end
    if (sel && cmd == CMD_MRS)
    begin
      mod_d = CNT_W'(MOD_P);                                   // [RQ8]
      case (link.ba)
        BA_MR1:
        begin
          dll_off_d = link.addr[MR1_DLL_OFF_BIT];              // [RQ1]
        end
        BA_MR0:
        begin
          cl_d = link.addr[MR0_CL_LSB +: LAT_W];
          if (link.addr[MR0_DLL_RST_BIT] && !dll_off_q)
          begin
            lock_d = CNT_W'(DLLK_P);                           // [RQ13]
          end
        end
        BA_MR2:
        begin
          cwl_d = link.addr[MR2_CWL_LSB +: LAT_W];
        end
        default:
        begin
          mod_d = CNT_W'(MOD_P);
        end
      endcase
    end
    rl_d = dll_off_d ? DLL_OFF_LAT : CL_BASE + 4'(cl_d);       // [RQ20]
    wl_d = dll_off_d ? DLL_OFF_LAT : CWL_BASE + 4'(cwl_d);     // [RQ20]
    // Status flags follow the next values so that they leave a flop.
    locked_d = !dll_off_d && lock_d == '0 && !sr_d;
    ready_d  = mod_d == '0 && !sr_d;                           // [RQ8]
  end

  // Register stage for the memory end.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cke_prev_q <= 1'b0;
      dll_off_q  <= 1'b0;
      sr_q       <= 1'b0;
      mod_q      <= '0;
      lock_q     <= '0;
      cl_q       <= '0;
      cwl_q      <= '0;
      rl_q       <= CL_BASE;
      wl_q       <= CWL_BASE;
      locked_q   <= 1'b1;
      ready_q    <= 1'b1;
    end
    else
    begin
      cke_prev_q <= link.cke;
      dll_off_q  <= dll_off_d;
      sr_q       <= sr_d;
      mod_q      <= mod_d;
      lock_q     <= lock_d;
      cl_q       <= cl_d;
      cwl_q      <= cwl_d;
      rl_q       <= rl_d;
      wl_q       <= wl_d;
      locked_q   <= locked_d;
      ready_q    <= ready_d;
    end
  end

  assign dll_off_o       = dll_off_q;
  assign dll_locked_o    = locked_q;
  assign self_refresh_o  = sr_q;
  assign cmd_ready_o     = ready_q;                              // [RQ8]
  assign read_latency_o  = rl_q;
  assign write_latency_o = wl_q;

endmodule // dram_dll_mode_end

//--- tb/dll_switch_props.sv
// Concurrent checks on the command link between the two ends.
`timescale 1ns/1ps
module dll_switch_props
  import dll_switch_pkg::*;
#(
  parameter int MOD_P = 12,
  parameter int MRD_P = 4,
  parameter int XS_P  = 15
)(
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BA_W-1:0]   ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              odt
);
  localparam int MOD_HI  = MOD_P + 3;
  localparam int XS_HI   = XS_P + 3;
  localparam int MRD_GAP = MRD_P + 1;
  logic [3:0] cmd;
  logic       mrs;
  logic       sr_in;
  logic       sr_q;
  logic       sr_d;
  logic       off_q;
  logic       off_d;
  logic       fresh_q;
  logic       fresh_d;
  // Decode the command lines.
  assign cmd   = {cs_n, ras_n, cas_n, we_n};
  assign mrs   = cke && cmd == CMD_MRS;
  assign sr_in = !cke && cmd == CMD_REF;
  // Track self refresh, the last DLL disable bit, and an off switch not yet past its exit.
  always_comb
  begin
    sr_d    = sr_in ? 1'b1 : (cke ? 1'b0 : sr_q);
    off_d   = (mrs && ba == BA_MR1) ? addr[MR1_DLL_OFF_BIT] : off_q;
    fresh_d = (mrs && ba == BA_MR1 && addr[MR1_DLL_OFF_BIT]) ? 1'b1 :
              ((sr_q && cke) ? 1'b0 : fresh_q);
  end
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      sr_q    <= 1'b0;
      off_q   <= 1'b0;
      fresh_q <= 1'b0;
    end
    else
    begin
      sr_q    <= sr_d;
      off_q   <= off_d;
      fresh_q <= fresh_d;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_odt_idle;
    mrs && ba == BA_MR1 && addr[MR1_DLL_OFF_BIT] |-> !odt;
  endproperty
  a_odt_idle: assert property (p_odt_idle) else $error("odt high at dll off write");
  property p_off_then_sr;
    mrs && ba == BA_MR1 && addr[MR1_DLL_OFF_BIT] |-> ##[MOD_P:MOD_HI] sr_in;
  endproperty
  a_off_then_sr: assert property (p_off_then_sr) else $error("self refresh entry mistimed");
  // Clock hold plus clock stable windows total four cycles here.
  property p_sr_clock;
    sr_in |=> !cke [*3];
  endproperty
  a_sr_clock: assert property (p_sr_clock) else $error("self refresh left too early");
  property p_cke_hold;
    sr_q && cke |-> cke [*8];
  endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("cke dropped after exit");
  property p_odt_low;
    sr_q |-> !odt;
  endproperty
  a_odt_low: assert property (p_odt_low) else $error("odt high in self refresh");
  property p_exit_mrs;
    sr_q && cke |-> ##[XS_P:XS_HI] mrs;
  endproperty
  a_exit_mrs: assert property (p_exit_mrs) else $error("mode write mistimed after exit");
  property p_on_first;
    sr_q && cke && off_q && !fresh_q |->
      ##[XS_P:XS_HI] (mrs && ba == BA_MR1 && !addr[MR1_DLL_OFF_BIT]);
  endproperty
  a_on_first: assert property (p_on_first) else $error("dll enable write missing");
  property p_dll_reset;
    mrs && ba == BA_MR1 && !addr[MR1_DLL_OFF_BIT] |->
      ##MRD_GAP (mrs && ba == BA_MR0 && addr[MR0_DLL_RST_BIT]);
  endproperty
  a_dll_reset: assert property (p_dll_reset) else $error("dll reset write missing");
  property p_spacing;
    mrs |=> !mrs [*3];
  endproperty
  a_spacing: assert property (p_spacing) else $error("mode writes too close");
  property p_off_lat;
    (mrs && off_q && ba == BA_MR0 |-> addr[MR0_CL_LSB +: LAT_W] == CL6_CODE) and
    (mrs && off_q && ba == BA_MR2 |-> addr[MR2_CWL_LSB +: LAT_W] == CWL6_CODE);
  endproperty
  a_off_lat: assert property (p_off_lat) else $error("latency not six with dll off");
  property p_sr_nop;
    sr_q && !cke |-> cs_n || cmd == CMD_NOP;
  endproperty
  a_sr_nop: assert property (p_sr_nop) else $error("command during self refresh");
  c_off: cover property (mrs && ba == BA_MR1 && addr[MR1_DLL_OFF_BIT]);
  c_reset: cover property (mrs && ba == BA_MR0 && addr[MR0_DLL_RST_BIT]);
  c_zq: cover property (cke && cmd == CMD_ZQ && addr[ZQ_LONG_BIT]);
endmodule // dll_switch_props

//--- tb/tb_top.sv
// Self-checking bench for both ends of the DLL on/off switch.
`timescale 1ns/1ps
module tb_top;
  import dll_switch_pkg::*;
  localparam int MOD_T  = 12;
  localparam int MRD_T  = 4;
  localparam int XS_T   = 15;
  localparam int SRE_T  = 2;
  localparam int SRX_T  = 2;
  localparam int LOCK_T = 8;
  localparam int ZQ_T   = 4;
  logic       clock_i;
  logic       rst_n_i;
  logic       start;
  logic       to_off;
  logic       zq;
  logic [2:0] cl;
  logic [2:0] write_latency;
  logic       odt_u;
  logic       busy;
  logic       done;
  logic       freq;
  logic       dll_off;
  logic       locked;
  logic       sr;
  logic       ready;
  logic [3:0] rl;
  logic [3:0] wl;
  logic       dll_off2;
  logic       locked2;
  logic       ready2;
  logic [3:0] rl2;
  logic [3:0] wl2;
  int         failures;
  int         samples_checked;
  int         n;
  ddr_cmd_if link();
  ddr_cmd_if link2();
  dll_mode_switch_sequencer #(.MOD_P(MOD_T), .MRD_P(MRD_T), .CKSRE_P(SRE_T), .CKSRX_P(SRX_T),
    .XS_P(XS_T), .DLLK_P(LOCK_T), .ZQOPER_P(ZQ_T)) dll_mode_switch_sequencer_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start), .to_dll_off_i(to_off),
    .zq_long_i(zq), .cl_code_i(cl), .cwl_code_i(write_latency), .odt_i(odt_u), .busy_o(busy),
    .done_o(done), .freq_change_o(freq), .link(link));
  dram_dll_mode_end #(.MOD_P(MOD_T), .DLLK_P(LOCK_T)) dram_dll_mode_end_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .link(link), .dll_off_o(dll_off),
    .dll_locked_o(locked), .self_refresh_o(sr), .cmd_ready_o(ready),
    .read_latency_o(rl), .write_latency_o(wl));
  // Second memory end, driven directly by the bench.
  dram_dll_mode_end #(.MOD_P(MOD_T), .DLLK_P(LOCK_T)) dram_dll_mode_end_inst2 (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .link(link2), .dll_off_o(dll_off2),
    .dll_locked_o(locked2), .self_refresh_o(), .cmd_ready_o(ready2),
    .read_latency_o(rl2), .write_latency_o(wl2));
  dll_switch_props #(.MOD_P(MOD_T), .MRD_P(MRD_T), .XS_P(XS_T)) dll_switch_props_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
    .addr(link.addr), .odt(link.odt));
  // Free-running 125 MHz clock.
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // Counts one comparison and reports a mismatch.
  task chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Issues one mode write on the second link, then returns to no-operation.
  task put(input logic sel_n, input logic [2:0] b, input logic [13:0] a);
    @(posedge clock_i);
    #1;
    {link2.cs_n, link2.ras_n, link2.cas_n, link2.we_n} = {sel_n, 3'h0};
    link2.ba = b;
    link2.addr = a;
    @(posedge clock_i);
    #1;
    {link2.cs_n, link2.ras_n, link2.cas_n, link2.we_n} = CMD_NOP;
    link2.addr = ~a;
  endtask
  // Counts cycles until ready or lock returns on the second memory end.
  task low_len(input logic sel, output int cnt);
    cnt = 0;
    while ((sel ? locked2 : ready2) !== 1'b1 && cnt < 600)
    begin
      @(posedge clock_i);
      #1;
      cnt++;
    end
  endtask
  // Runs one switch; start is held a few cycles more to show it is ignored while busy.
  task run(input logic off, input logic zl, input logic [2:0] c, input logic [2:0] w);
    int fc;
    int lk;
    int sr_seen;
    int lo;
    @(posedge clock_i);
    #1;
    {start, to_off, zq, cl, write_latency} = {1'b1, off, zl, c, w};
    n = 0;
    fc = 0;
    lk = 0;
    sr_seen = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clock_i);
      #1;
      n++;
      start = (n < 4);
      fc += int'(freq === 1'b1);
      lk += int'(locked === 1'b0);
      sr_seen += int'(sr === 1'b1);
    end
    if (n >= 3000)
    begin
      failures++;
      $display("wrong value at %0t: switch never finished", $time);
      results;
    end
    lo = 1 + SRE_T + SRX_T + XS_T + MRD_T + (zl ? ZQ_T : 0);
    lo += off ? 2 * MOD_T : ((MRD_T + MOD_T > LOCK_T) ? MRD_T + MOD_T : LOCK_T);
    chk(n >= lo && n <= lo + 16, "switch length");
    chk(fc == SRX_T + 1, "frequency change window");
    chk(sr_seen > 0, "self refresh never entered");
    if (off)
      chk(dll_off === 1'b1 && rl === DLL_OFF_LAT && wl === DLL_OFF_LAT, "dll off state");
    else
      chk(dll_off === 1'b0 && locked === 1'b1 && lk >= LOCK_T, "dll on state");
    if (!off)
      chk(rl === CL_BASE + c && wl === CWL_BASE + w, "latencies after dll on");
    @(posedge clock_i);
    #1;
    chk(done === 1'b0 && busy === 1'b0 && ready === 1'b1, "single completion");
  endtask
  // Main sequence.
  initial
  begin
    failures = 0;
    samples_checked = 0;
    {rst_n_i, start, to_off, zq, cl, write_latency, odt_u} = {4'h0, 6'h00, 1'b1};
    link2.cke = 1'b1;
    {link2.cs_n, link2.ras_n, link2.cas_n, link2.we_n} = CMD_NOP;
    link2.ba = 3'h0;
    link2.addr = 14'h0000;
    repeat (12) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    repeat (2) @(posedge clock_i);
    put(1'b1, BA_MR1, 14'h0001);
    chk(dll_off2 === 1'b0 && ready2 === 1'b1, "deselected write taken");
    put(1'b0, BA_MR1, 14'h0001);
    chk(dll_off2 === 1'b1 && rl2 === DLL_OFF_LAT && wl2 === DLL_OFF_LAT, "dll off");
    low_len(1'b0, n);
    chk(n == MOD_T, "update delay length");
    put(1'b0, BA_MR0, 14'h0100);
    repeat (2) @(posedge clock_i);
    put(1'b0, BA_MR1, 14'h0000);
    chk(dll_off2 === 1'b0 && locked2 === 1'b1, "reset while off started lock");
    repeat (2) @(posedge clock_i);
    put(1'b0, BA_MR0, 14'h0100);
    low_len(1'b1, n);
    chk(n == LOCK_T, "lock time length");
    run(1'b1, 1'b1, 3'h0, 3'h0);
    for (int i = 0; i < 8; i++)
      run(1'b0, i[0], i[2:0], 3'(7 - i));
    run(1'b1, 1'b0, 3'h0, 3'h0);
    results;
  end
endmodule // tb_top
